// ==== core/sbcreg_pkg.sv ====
// sbcreg_pkg: frame layout, register addresses, field positions and encodings
// for the serial register bank. assumes a 7-bit address space, byte registers.
package sbcreg_pkg;

  // ----------------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------------
  localparam int         FRAME_BITS = 16;
  localparam int         ACC_BIT    = 7;
  localparam int         DATA_LSB   = 8;
  localparam logic [4:0] CNT_FULL   = 5'h10;
  localparam logic [4:0] CNT_MAX    = 5'h1f;
  localparam logic [4:0] CNT_HALF   = 5'h08;

  // ----------------------------------------------------------------------
  // control registers (read / write)
  // ----------------------------------------------------------------------
  localparam logic [6:0] A_MODE_SUPPLY_CONTROL = 7'h01, A_HARDWARE_CONTROL = 7'h02, A_WATCHDOG_CONTROL = 7'h03;
  localparam logic [6:0] A_BUS_CONTROL_ONE = 7'h04, A_BUS_CONTROL_TWO = 7'h05, A_WAKE_CONTROL_ONE = 7'h06;
  localparam logic [6:0] A_WAKE_CONTROL_TWO = 7'h07, A_WAKE_PULL_CONTROL = 7'h08, A_WAKE_FILTER_CONTROL = 7'h09;
  localparam logic [6:0] A_TIMER_ONE_CONTROL = 7'h0c, A_TIMER_TWO_CONTROL = 7'h0d, A_SWITCH_SHUTDOWN_CONTROL = 7'h10;
  localparam logic [6:0] A_HIGHSIDE_CONTROL_ONE = 7'h14, A_HIGHSIDE_CONTROL_TWO = 7'h15, A_GENERAL_IO_CONTROL = 7'h17;
  localparam logic [6:0] A_PULSE_WIDTH_ONE_CONTROL = 7'h18, A_PULSE_WIDTH_TWO_CONTROL = 7'h19;
  localparam logic [6:0] A_PULSE_FREQUENCY_CONTROL = 7'h1c, A_SYSTEM_SCRATCH_CONTROL = 7'h1e;
  localparam logic [6:0] A_SELECTIVE_WAKE_CONTROL = 7'h20, A_WAKE_BIT_TIMING_ONE = 7'h21, A_WAKE_BIT_TIMING_TWO = 7'h22;
  localparam logic [6:0] A_WAKE_IDENTIFIER_BYTE3 = 7'h23, A_WAKE_IDENTIFIER_BYTE2 = 7'h24;
  localparam logic [6:0] A_WAKE_IDENTIFIER_BYTE1 = 7'h25, A_WAKE_IDENTIFIER_BYTE0 = 7'h26;
  localparam logic [6:0] A_WAKE_IDENTIFIER_MASK3 = 7'h27, A_WAKE_IDENTIFIER_MASK2 = 7'h28;
  localparam logic [6:0] A_WAKE_IDENTIFIER_MASK1 = 7'h29, A_WAKE_IDENTIFIER_MASK0 = 7'h2a;
  localparam logic [6:0] A_WAKE_FRAME_LENGTH_CONTROL = 7'h2b;
  // one bit per writable address below 7'h40
  localparam logic [63:0] CTRL_MAP = 64'h0000_0fff_53b1_33fe;
  localparam logic [7:0]  CTRL_RST = 8'h00;

  // ----------------------------------------------------------------------
  // status registers: clearable slots, then read-only slots
  // ----------------------------------------------------------------------
  localparam int         N_STAT = 9;
  localparam logic [6:0] STAT_ADDR [N_STAT] = '{7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h46, 7'h47, 7'h54, 7'h55};
  localparam int         N_RO = 7;
  // wake pin level, calibration high/low, selective wake status, error count, recovery one/two
  localparam logic [6:0] RO_ADDR [N_RO] = '{7'h48, 7'h3a, 7'h3b, 7'h70, 7'h71, 7'h72, 7'h73};
  localparam logic [6:0] A_FAMILY_PRODUCT_ID_STATUS = 7'h7e;

  // ----------------------------------------------------------------------
  // fields and encodings
  // ----------------------------------------------------------------------
  localparam int         MODE_HI = 7, MODE_LO = 6, AUXILIARY_SUPPLY_OUTPUT_HI = 4, AUXILIARY_SUPPLY_OUTPUT_LO = 3, FO_ON_BIT = 5, CAN_HI = 2, CAN_LO = 0;
  localparam logic [1:0] MODE_NORMAL = 2'h0, MODE_SLEEP = 2'h1, MODE_STOP = 2'h2, MODE_RESTART = 2'h3;
  localparam logic [2:0] CAN_OFF = 3'h0, CAN_WAKE_CAP = 3'h1;

endpackage

// ==== core/sbcreg_link_if.sv ====
// sbcreg_link_if: carries the captured frame and the answer bits between the
// serial-clock engine and the register core. assumes the core holds field and
// first_bit static while the chip select is low; rd_data follows live registers.
`timescale 1ns/1ns
interface sbcreg_link_if;
  logic [15:0] rx_word;
  logic [4:0]  bit_cnt;
  logic        frm_tgl;
  logic [7:0]  field;
  logic        first_bit;
  logic [7:0]  rd_data;

  modport engine (output rx_word, output bit_cnt, output frm_tgl,
                  input field, input first_bit, input rd_data);
  modport core   (input rx_word, input bit_cnt, input frm_tgl,
                  output field, output first_bit, output rd_data);
endinterface

// ==== core/sbcreg_spi_engine.sv ====
// sbcreg_spi_engine: shift logic on the serial clock; counts clocks per frame,
// collects the 16 input bits lsb first and shifts the answer out.
// assumes the serial clock idles low and stands still while chip select is high.
`timescale 1ns/1ns
module sbcreg_spi_engine (
  input  wire logic      sclk_i,
  input  wire logic      rst_n_i,
  input  wire logic      csn_i,
  input  wire logic      sdi_i,
  output logic           sdo_o,
  sbcreg_link_if.engine  link
);

  logic        fresh_reg;
  logic [4:0]  cnt_reg;
  logic [15:0] rx_reg;
  logic        tgl_reg;
  logic        tx_reg;
  logic        tx_next;

  // ----------------------------------------------------------------------
  // frame start, armed by the select going high, ended by the first clock
  // ----------------------------------------------------------------------
  // reset too, so the very first frame never starts from an unknown count
  always_ff @(posedge sclk_i or posedge csn_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fresh_reg <= 1'b1;
    end else if (csn_i) begin
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= 1'b0;
    end
  end

  // count saturates so 48 clocks never alias to 16
  always_ff @(posedge sclk_i) begin
    if (fresh_reg) begin
      cnt_reg   <= 5'h01;
      rx_reg[0] <= sdi_i;
    end else begin
      if (cnt_reg != sbcreg_pkg::CNT_MAX) begin
        cnt_reg <= cnt_reg + 5'h01;
      end
      if (cnt_reg < sbcreg_pkg::CNT_FULL) begin
        rx_reg[cnt_reg[3:0]] <= sdi_i;
      end
    end
  end

  // one toggle per clocked frame tells the core a zero-clock frame apart
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgl_reg <= 1'b0;
    end else if (fresh_reg) begin
      tgl_reg <= ~tgl_reg;
    end
  end

  // ----------------------------------------------------------------------
  // answer: status field first, then the addressed byte
  // ----------------------------------------------------------------------
  always_comb begin
    if (cnt_reg < sbcreg_pkg::CNT_HALF) begin
      tx_next = link.field[cnt_reg[2:0]];
    end else if (cnt_reg < sbcreg_pkg::CNT_FULL) begin
      tx_next = link.rd_data[cnt_reg[2:0]];
    end else begin
      tx_next = 1'b0;
    end
  end

  always_ff @(negedge sclk_i) begin
    tx_reg <= tx_next;
  end

  // before the first clock the pin shows the flag bit prepared by the core
  assign sdo_o          = fresh_reg ? link.first_bit : tx_reg; // R15
  assign link.rx_word   = rx_reg;
  assign link.bit_cnt   = cnt_reg;
  assign link.frm_tgl   = tgl_reg;

endmodule // sbcreg_spi_engine

// ==== core/sbcreg_top.sv ====
// sbcreg_top: register bank of the device behind its 16-bit serial port.
// assumes mode changes, switch faults and status events come from logic on
// mclk_i; the serial port pins come from the host and its own clock.
//
// Function
// R1 - frame is 16 bits: address bits 6..0, access bit 7, data bits 15..8
// R2 - control registers return their byte; access bit set also stores the data
// R3 - a written value shows only in a later frame to that register
// R4 - status registers return their byte; access bit set clears its clearable bits
// R5 - level, identity, calibration and wake diagnostic registers are read-only, ignore clears
// R6 - host should clear flags; drivers may still be enabled with flags set
// R7 - every mode change rewrites the mode bits to the mode entered
// R8 - entering stop or sleep keeps diagnosis bits and an active fail output
// R9 - entering stop leaves the transceiver control bits as they are
// R10 - entering sleep forces transceiver bits to wake-capable unless off or wake-capable
// R11 - switch and auxiliary supply settings stay on and change only in normal mode
// R12 - switch fault in low power turns that switch off, raises no wake
// R13 - restart clears switch and supply settings, keeps fail output, parks transceiver
// R14 - frames during restart are ignored
// R15 - clock count other than 0 or 16 discards frame, flags error before next frame
// R16 - each answer carries a summary byte, one bit per status register; 7'h46 and 7'h47 share bit 4
`timescale 1ns/1ns
module sbcreg_top #(
  parameter logic [7:0] FAMILY_ID = 8'h5a  // arbitrary identification value
) (
  input  wire logic            mclk_i,
  input  wire logic            rst_n_i,
  input  wire logic            sclk_i,
  input  wire logic            csn_i,
  input  wire logic            sdi_i,
  output logic                 sdo_o,
  output logic                 sdo_oe_o,
  input  wire logic [1:0]      mode_i,
  input  wire logic            mode_chg_i,
  input  wire logic [1:0]      hs_fault_i,
  input  wire logic [8:0][7:0] stat_evt_i,
  input  wire logic [6:0][7:0] ro_stat_i,
  output logic [1:0]           mode_sel_o,
  output logic [1:0]           auxiliary_supply_output_on_o,
  output logic                 fail_out_on_o,
  output logic [2:0]           can_mode_o,
  output logic [7:0]           hs_cfg_one_o,
  output logic [7:0]           hs_cfg_two_o,
  output logic                 ctrl_wr_o,
  output logic [6:0]           ctrl_addr_o,
  output logic [7:0]           ctrl_data_o,
  output logic                 spi_err_o
);

  // ----------------------------------------------------------------------
  // serial engine on the link clock
  // ----------------------------------------------------------------------
  sbcreg_link_if link ();

  sbcreg_spi_engine u_engine (
    .sclk_i  (sclk_i),
    .rst_n_i (rst_n_i),
    .csn_i   (csn_i),
    .sdi_i   (sdi_i),
    .sdo_o   (sdo_o),
    .link    (link.engine)
  );

  // the pin is released whenever the host is not selecting us
  assign sdo_oe_o = ~csn_i;

  // ----------------------------------------------------------------------
  // crossing into mclk
  // ----------------------------------------------------------------------
  logic csn_s1_reg;
  logic csn_s2_reg;
  logic csn_s3_reg;
  logic tgl_s1_reg;
  logic tgl_s2_reg;
  logic tgl_seen_reg;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      csn_s1_reg <= 1'b1;
      csn_s2_reg <= 1'b1;
      csn_s3_reg <= 1'b1;
    end else begin
      csn_s1_reg <= csn_i;
      csn_s2_reg <= csn_s1_reg;
      csn_s3_reg <= csn_s2_reg;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
    end else begin
      tgl_s1_reg <= link.frm_tgl;
      tgl_s2_reg <= tgl_s1_reg;
    end
  end

  // word and count sit still once the select is high, so they are taken
  // only after the select has passed the synchroniser
  logic       frame_end;
  logic       clocked;
  logic       bad_len;
  logic       in_restart;
  logic       exec;
  logic [6:0] f_addr;
  logic       f_acc;
  logic [7:0] f_data;
  logic       ctrl_wr;
  logic       restart_hit_reg;

  assign frame_end  = csn_s2_reg & ~csn_s3_reg;
  assign clocked    = tgl_s2_reg != tgl_seen_reg;
  assign bad_len    = clocked && (link.bit_cnt != sbcreg_pkg::CNT_FULL); // R15
  assign in_restart = restart_hit_reg || (mode_i == sbcreg_pkg::MODE_RESTART); // R14
  assign exec       = frame_end && clocked && !bad_len && !in_restart; // R15
  assign f_addr     = link.rx_word[sbcreg_pkg::ACC_BIT-1:0]; // R1
  assign f_acc      = link.rx_word[sbcreg_pkg::ACC_BIT]; // R1
  assign f_data     = link.rx_word[sbcreg_pkg::FRAME_BITS-1:sbcreg_pkg::DATA_LSB]; // R1
  assign ctrl_wr    = exec && f_acc && !f_addr[6] && sbcreg_pkg::CTRL_MAP[f_addr[5:0]]; // R2

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgl_seen_reg <= 1'b0;
    end else if (frame_end) begin
      tgl_seen_reg <= tgl_s2_reg;
    end
  end

  // a frame that merely overlaps restart is spoiled as well
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      restart_hit_reg <= 1'b0;
    end else if (frame_end) begin
      restart_hit_reg <= 1'b0;
    end else if (!csn_s2_reg && mode_i == sbcreg_pkg::MODE_RESTART) begin
      restart_hit_reg <= 1'b1; // R14
    end
  end

  // ----------------------------------------------------------------------
  // error flag
  // ----------------------------------------------------------------------
  logic err_reg;

  // zero-clock frames neither execute nor clear, so the flag can be polled
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_reg <= 1'b0;
    end else if (frame_end && clocked && (bad_len || in_restart)) begin
      err_reg <= 1'b1; // R15
    end else if (exec) begin
      err_reg <= 1'b0;
    end
  end

  assign spi_err_o = err_reg;

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] entry_next(input logic [6:0] addr,
                                            input logic [7:0] cur,
                                            input logic       hit,
                                            input logic [7:0] wdat,
                                            input logic [1:0] mode,
                                            input logic       chg,
                                            input logic [1:0] fault);
    logic [7:0] v;
    logic       normal;
    logic [2:0] can;
    v      = cur;
    normal = mode == sbcreg_pkg::MODE_NORMAL;
    can    = cur[sbcreg_pkg::CAN_HI:sbcreg_pkg::CAN_LO];
    if (hit) begin
      v = wdat; // R2
      if (addr == sbcreg_pkg::A_MODE_SUPPLY_CONTROL && !normal) begin
        v[sbcreg_pkg::AUXILIARY_SUPPLY_OUTPUT_HI:sbcreg_pkg::AUXILIARY_SUPPLY_OUTPUT_LO] = cur[sbcreg_pkg::AUXILIARY_SUPPLY_OUTPUT_HI:sbcreg_pkg::AUXILIARY_SUPPLY_OUTPUT_LO]; // R11
      end
      // no check of failure flags: drivers may be enabled with flags set
      if ((addr == sbcreg_pkg::A_HIGHSIDE_CONTROL_ONE || addr == sbcreg_pkg::A_HIGHSIDE_CONTROL_TWO)
          && !normal) begin
        v = cur; // R11 R6
      end
    end
    // a detected switch fault only turns the switch off, nothing else
    if ((addr == sbcreg_pkg::A_HIGHSIDE_CONTROL_ONE && fault[0])
        || (addr == sbcreg_pkg::A_HIGHSIDE_CONTROL_TWO && fault[1])) begin
      v = 8'h00; // R12
    end
    if (chg) begin
      if (addr == sbcreg_pkg::A_MODE_SUPPLY_CONTROL) begin
        v[sbcreg_pkg::MODE_HI:sbcreg_pkg::MODE_LO] = mode; // R7
        if (mode == sbcreg_pkg::MODE_RESTART) begin
          v[sbcreg_pkg::AUXILIARY_SUPPLY_OUTPUT_HI:sbcreg_pkg::AUXILIARY_SUPPLY_OUTPUT_LO] = 2'h0; // R13
        end
      end
      if ((addr == sbcreg_pkg::A_HIGHSIDE_CONTROL_ONE || addr == sbcreg_pkg::A_HIGHSIDE_CONTROL_TWO)
          && mode == sbcreg_pkg::MODE_RESTART) begin
        v = 8'h00; // R13
      end
      // stop leaves the transceiver bits untouched
      if (addr == sbcreg_pkg::A_BUS_CONTROL_ONE && mode != sbcreg_pkg::MODE_STOP
          && mode != sbcreg_pkg::MODE_NORMAL
          && can != sbcreg_pkg::CAN_OFF && can != sbcreg_pkg::CAN_WAKE_CAP) begin
        v[sbcreg_pkg::CAN_HI:sbcreg_pkg::CAN_LO] = sbcreg_pkg::CAN_WAKE_CAP; // R9 R10 R13
      end
    end
    return v;
  endfunction

  wire [7:0] ctrl_q [64];

  // the fail output bit is never touched by a mode change
  genvar gi;
  generate
    for (gi = 0; gi < 64; gi++) begin : g_ctrl
      if (sbcreg_pkg::CTRL_MAP[gi]) begin : g_used
        logic [7:0] q_reg;
        always_ff @(posedge mclk_i or negedge rst_n_i) begin
          if (!rst_n_i) begin
            q_reg <= sbcreg_pkg::CTRL_RST;
          end else begin
            q_reg <= entry_next(7'(gi), q_reg, ctrl_wr && (f_addr[5:0] == 6'(gi)), f_data,
                                mode_i, mode_chg_i, hs_fault_i); // R8 R13
          end
        end
        assign ctrl_q[gi] = q_reg;
      end else begin : g_hole
        assign ctrl_q[gi] = 8'h00;
      end
    end
  endgenerate

  assign mode_sel_o    = ctrl_q[sbcreg_pkg::A_MODE_SUPPLY_CONTROL[5:0]][sbcreg_pkg::MODE_HI:sbcreg_pkg::MODE_LO];
  assign auxiliary_supply_output_on_o     = ctrl_q[sbcreg_pkg::A_MODE_SUPPLY_CONTROL[5:0]][sbcreg_pkg::AUXILIARY_SUPPLY_OUTPUT_HI:sbcreg_pkg::AUXILIARY_SUPPLY_OUTPUT_LO];
  assign fail_out_on_o = ctrl_q[sbcreg_pkg::A_HARDWARE_CONTROL[5:0]][sbcreg_pkg::FO_ON_BIT]; // R8
  assign can_mode_o    = ctrl_q[sbcreg_pkg::A_BUS_CONTROL_ONE[5:0]][sbcreg_pkg::CAN_HI:sbcreg_pkg::CAN_LO];
  assign hs_cfg_one_o  = ctrl_q[sbcreg_pkg::A_HIGHSIDE_CONTROL_ONE[5:0]];
  assign hs_cfg_two_o  = ctrl_q[sbcreg_pkg::A_HIGHSIDE_CONTROL_TWO[5:0]];

  // every accepted write is also passed on, e.g. for watchdog triggers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_wr_o   <= 1'b0;
      ctrl_addr_o <= 7'h00;
      ctrl_data_o <= 8'h00;
    end else begin
      ctrl_wr_o <= ctrl_wr;
      if (ctrl_wr) begin
        ctrl_addr_o <= f_addr;
        ctrl_data_o <= f_data;
      end
    end
  end

  // ----------------------------------------------------------------------
  // clearable status registers
  // ----------------------------------------------------------------------
  logic [7:0] stat_q [sbcreg_pkg::N_STAT];

  // an event in the clearing cycle survives: set is applied after the clear
  generate
    for (gi = 0; gi < sbcreg_pkg::N_STAT; gi++) begin : g_stat
      logic clr;
      assign clr = exec && f_acc && (f_addr == sbcreg_pkg::STAT_ADDR[gi]); // R4
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          stat_q[gi] <= 8'h00;
        end else begin
          stat_q[gi] <= (clr ? 8'h00 : stat_q[gi]) | stat_evt_i[gi]; // R4 R8
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // summary byte and first answer bit
  // ----------------------------------------------------------------------
  logic [7:0] field_next;
  logic [7:0] field_reg;
  logic       first_reg;

  always_comb begin
    field_next[0] = |stat_q[1]; // R16
    field_next[1] = |stat_q[2];
    field_next[2] = |stat_q[3];
    field_next[3] = |stat_q[4];
    field_next[4] = |stat_q[5] | |stat_q[6];
    field_next[5] = |stat_q[0];
    field_next[6] = |stat_q[7];
    field_next[7] = |stat_q[8];
  end

  // frozen while selected so the engine never sees it move mid-frame
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      field_reg <= 8'h00;
      first_reg <= 1'b0;
    end else if (csn_s2_reg) begin
      field_reg <= field_next; // R16
      first_reg <= field_next[0] | err_reg; // R15
    end
  end

  assign link.field     = field_reg;
  assign link.first_bit = first_reg;

  // ----------------------------------------------------------------------
  // read data for the addressed byte
  // ----------------------------------------------------------------------
  // limitation: read straight from live registers; values changing inside
  // the 8 clocks of the data half may be seen torn by the host
  logic [6:0] rd_addr;
  logic [7:0] rd_data;

  assign rd_addr = link.rx_word[sbcreg_pkg::ACC_BIT-1:0];

  always_comb begin
    rd_data = 8'h00;
    if (!rd_addr[6]) begin
      rd_data = ctrl_q[rd_addr[5:0]]; // R2 R3
    end
    for (int i = 0; i < sbcreg_pkg::N_STAT; i++) begin
      if (rd_addr == sbcreg_pkg::STAT_ADDR[i]) begin
        rd_data = stat_q[i]; // R4
      end
    end
    // read-only slots have no clear path at all
    for (int i = 0; i < sbcreg_pkg::N_RO; i++) begin
      if (rd_addr == sbcreg_pkg::RO_ADDR[i]) begin
        rd_data = ro_stat_i[i]; // R5
      end
    end
    if (rd_addr == sbcreg_pkg::A_FAMILY_PRODUCT_ID_STATUS) begin
      rd_data = FAMILY_ID; // R5
    end
  end

  assign link.rd_data = rd_data;

endmodule // sbcreg_top

// ==== tb/sbcreg_props.sv ====
// sbcreg_props: concurrent checks on the register bank ports.
// assumes binding into sbcreg_top; sees its ports only.
`timescale 1ns/1ns
module sbcreg_props (
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  input wire logic       csn_i,
  input wire logic       sdo_oe_o,
  input wire logic [1:0] mode_i,
  input wire logic       mode_chg_i,
  input wire logic [1:0] hs_fault_i,
  input wire logic [1:0] mode_sel_o,
  input wire logic [1:0] auxiliary_supply_output_on_o,
  input wire logic       fail_out_on_o,
  input wire logic [2:0] can_mode_o,
  input wire logic [7:0] hs_cfg_one_o,
  input wire logic [7:0] hs_cfg_two_o,
  input wire logic       ctrl_wr_o,
  input wire logic [6:0] ctrl_addr_o,
  input wire logic       spi_err_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ----
  // properties
  // ----
  a_oe_follows_cs: assert property (sdo_oe_o == !csn_i) else $error("oe wrong");
  a_wr_one_pulse: assert property (ctrl_wr_o |=> !ctrl_wr_o) else $error("wr pulse long");
  a_wr_mapped_only: assert property (ctrl_wr_o |->
    !ctrl_addr_o[6] && sbcreg_pkg::CTRL_MAP[ctrl_addr_o[5:0]]) else $error("wr unmapped");
  a_restart_no_wr: assert property (mode_i == sbcreg_pkg::MODE_RESTART [*8] |-> !ctrl_wr_o)
    else $error("wr in restart");
  a_mode_bits_track: assert property (mode_chg_i |=> mode_sel_o == $past(mode_i)) else $error("mode bits");
  a_fail_out_kept: assert property (mode_chg_i && fail_out_on_o |=> fail_out_on_o) else $error("fail lost");
  a_stop_keeps_can: assert property (mode_chg_i && mode_i == sbcreg_pkg::MODE_STOP |=> $stable(can_mode_o))
    else $error("can moved");
  a_sleep_parks_can: assert property (mode_chg_i && mode_i == sbcreg_pkg::MODE_SLEEP && can_mode_o > 3'h1
    |=> can_mode_o == sbcreg_pkg::CAN_WAKE_CAP) else $error("can not parked");
  a_restart_clears: assert property (mode_chg_i && mode_i == sbcreg_pkg::MODE_RESTART
    |=> auxiliary_supply_output_on_o == 2'h0 && hs_cfg_one_o == 8'h00 && hs_cfg_two_o == 8'h00) else $error("restart kept cfg");
  a_hs_normal_only: assert property (hs_cfg_one_o != $past(hs_cfg_one_o) |->
    $past(mode_i) == sbcreg_pkg::MODE_NORMAL || $past(mode_chg_i) || $past(hs_fault_i[0])) else $error("hs moved");
  a_fault_clears_hs: assert property (hs_fault_i[1] |=> hs_cfg_two_o == 8'h00) else $error("fault kept hs");
  c_write: cover property (ctrl_wr_o);
  c_restart: cover property (mode_chg_i && mode_i == sbcreg_pkg::MODE_RESTART);
  c_error: cover property ($rose(spi_err_o));
endmodule // sbcreg_props

bind sbcreg_top sbcreg_props sbcreg_props_i (.mclk_i, .rst_n_i, .csn_i, .sdo_oe_o, .mode_i, .mode_chg_i,
  .hs_fault_i, .mode_sel_o, .auxiliary_supply_output_on_o, .fail_out_on_o, .can_mode_o, .hs_cfg_one_o, .hs_cfg_two_o,
  .ctrl_wr_o, .ctrl_addr_o, .spi_err_o);

// ==== tb/sbcreg_host.sv ====
// sbcreg_host: host model, master of frames and of the serial clock.
// assumes the bench calls frame() one at a time.
`timescale 1ns/1ns
module sbcreg_host (
  output logic      sclk_o,
  output logic      csn_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  initial begin
    sclk_o = 1'b0;
    csn_o = 1'b1;
    sdi_o = 1'b0;
  end
  // clock stands still outside frames, 80 ns inside; low at csn edges
  task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    csn_o = 1'b0;
    #120;
    for (int i = 0; i < n; i++) begin
      sdi_o = tx[i % 16];
      #40 rx[i % 16] = sdo_i;
      sclk_o = 1'b1;
      #40 sclk_o = 1'b0;
    end
    #120 csn_o = 1'b1;
    sdi_o = ~sdi_o;
    #400;
  endtask
endmodule // sbcreg_host

// ==== tb/sbcreg_top_tb_top.sv ====
// sbcreg_top_tb_top: self-checking bench for the serial register bank.
// assumes the host model owns the serial pins; this module drives the rest.
`timescale 1ns/1ns
module sbcreg_top_tb_top;
  logic            mclk_i = 1'b0;
  logic            rst_n_i = 1'b1;
  logic            sclk, csn, sdi, sdo, sdo_oe, sdo_w, fo, wr, err, chg = 1'b0, erf = 1'b0, sdo_q = 1'b0;
  logic [1:0]      mode = 2'h0, flt = 2'h0, msel, auxiliary_supply_output;
  logic [8:0][7:0] evt = '0;
  logic [6:0][7:0] ro;
  logic [2:0]      can;
  logic [7:0]      hs1, hs2, wdat, d, s40 = 8'h00;
  logic [6:0]      waddr, a;
  logic [7:0]      cm [128];
  logic [15:0]     rx, exp_q [$], got_q [$], wr_q [$];
  int              num_errors = 0, n_checks = 0, cyc = 0;
  always #25 mclk_i = ~mclk_i;
  // undriven line shows the inverse of its last value
  always @(posedge mclk_i) if (sdo_oe) sdo_q <= sdo;
  assign sdo_w = sdo_oe ? sdo : ~sdo_q;
  sbcreg_top #(.FAMILY_ID(8'h3c)) sbcreg_top_i (.mclk_i, .rst_n_i, .sclk_i(sclk), .csn_i(csn), .sdi_i(sdi),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe), .mode_i(mode), .mode_chg_i(chg), .hs_fault_i(flt), .stat_evt_i(evt),
    .ro_stat_i(ro), .mode_sel_o(msel), .auxiliary_supply_output_on_o(auxiliary_supply_output), .fail_out_on_o(fo), .can_mode_o(can), .hs_cfg_one_o(hs1),
    .hs_cfg_two_o(hs2), .ctrl_wr_o(wr), .ctrl_addr_o(waddr), .ctrl_data_o(wdat), .spi_err_o(err));
  sbcreg_host sbcreg_host_i (.sclk_o(sclk), .csn_o(csn), .sdi_o(sdi), .sdo_i(sdo_w));
  // ----
  // checking and closing
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    if (got_q.size() > 0) chk(got_q.pop_front(), exp_q.pop_front());
    if (wr === 1'b1) chk({1'b0, waddr, wdat}, wr_q.size() > 0 ? wr_q.pop_front() : 16'hffff);
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  // ----
  // frame helpers
  // ----
  task automatic xfer(input logic [6:0] ad, input logic acc, input logic [7:0] dt, input logic [7:0] old);
    logic [15:0] r;
    sbcreg_host_i.frame({dt, acc, ad}, 16, r);
    exp_q.push_back({old, 2'b00, |s40, 4'h0, erf});
    got_q.push_back(r);
    erf = 1'b0;
  endtask
  task automatic wrc(input logic [6:0] ad, input logic [7:0] dt);
    logic [7:0] o;
    o = cm[ad];
    if (sbcreg_pkg::CTRL_MAP[ad]) begin
      wr_q.push_back({1'b0, ad, dt});
      cm[ad] = dt;
    end
    xfer(ad, 1'b1, dt, o);
  endtask
  task automatic mchg(input logic [1:0] m);
    @(negedge mclk_i);
    mode = m;
    chg = 1'b1;
    @(negedge mclk_i);
    chg = 1'b0;
    @(negedge mclk_i);
  endtask
  initial begin
    for (int i = 0; i < 128; i++) cm[i] = 8'h00;
    // a real falling edge, so the link-clock flops are reset too
    #1 rst_n_i = 1'b0;
    void'($urandom(32'h1487f8cd));
    for (int i = 0; i < 7; i++) ro[i] = 8'($urandom);
    repeat (16) @(negedge mclk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    for (int k = 0; k < 10; k++) begin
      a = k == 0 ? 7'h00 : 7'($urandom_range(1, 43));
      wrc(a, 8'($urandom));
      xfer(a, 1'b0, 8'h00, cm[a]);
    end
    @(negedge mclk_i);
    d = 8'($urandom) | 8'h01;
    evt[0] = d;
    @(negedge mclk_i);
    evt[0] = 8'h00;
    s40 = d;
    xfer(7'h40, 1'b0, 8'h00, d);
    xfer(7'h40, 1'b1, 8'h00, d);
    s40 = 8'h00;
    xfer(7'h40, 1'b0, 8'h00, 8'h00);
    for (int i = 0; i < 7; i++) xfer(sbcreg_pkg::RO_ADDR[i], 1'b1, 8'h00, ro[i]);
    xfer(7'h48, 1'b0, 8'h00, ro[0]);
    xfer(7'h7e, 1'b1, 8'h00, 8'h3c);
    for (int n = 1; n < 18; n += 16) begin
      sbcreg_host_i.frame({8'ha5, 1'b1, 7'h05}, n, rx);
      chk({15'h0, err}, 16'h0001);
      erf = 1'b1;
      xfer(7'h05, 1'b0, 8'h00, cm[5]);
      chk({15'h0, err}, 16'h0000);
    end
    wrc(7'h04, 8'h05);
    wrc(7'h02, 8'h20);
    wrc(7'h14, 8'h81);
    wrc(7'h15, 8'h42);
    wrc(7'h01, 8'h18);
    mchg(sbcreg_pkg::MODE_SLEEP);
    chk({2'b00, msel, can, fo, hs1}, {2'b00, 2'h1, 3'h1, 1'b1, 8'h81});
    cm[4] = 8'h01;
    mchg(sbcreg_pkg::MODE_NORMAL);
    wrc(7'h04, 8'h06);
    mchg(sbcreg_pkg::MODE_STOP);
    chk({1'b0, msel, can, auxiliary_supply_output, hs2}, {1'b0, 2'h2, 3'h6, 2'h3, 8'h42});
    mchg(sbcreg_pkg::MODE_RESTART);
    chk({hs1, hs2}, 16'h0000);
    chk({10'h000, auxiliary_supply_output, can, fo}, {10'h000, 2'h0, 3'h1, 1'b1});
    sbcreg_host_i.frame({8'h77, 1'b1, 7'h04}, 16, rx);
    chk({12'h000, err, can}, {12'h000, 1'b1, 3'h1});
    erf = 1'b1;
    mchg(sbcreg_pkg::MODE_NORMAL);
    cm[4] = 8'h01;
    cm[20] = 8'h00;
    cm[21] = 8'h00;
    xfer(7'h02, 1'b0, 8'h00, 8'h20);
    wrc(7'h14, 8'h99);
    wrc(7'h15, 8'h3c);
    mchg(sbcreg_pkg::MODE_STOP);
    flt = 2'b10;
    @(negedge mclk_i);
    flt = 2'b00;
    @(negedge mclk_i);
    chk({hs1, hs2}, {8'h99, 8'h00});
    repeat (10) @(negedge mclk_i);
    chk(16'(wr_q.size()), 16'h0000);
    results();
  end
endmodule // sbcreg_top_tb_top
